// ===== rtl/sfs_core.sv
/*
  FIFO levels, port status, interrupt mask/status and receive sample delay of a synchronous
  serial port. Assumes a serial shift engine on the same clock that reports transfer start,
  activity, pops and pushes, and a register master that never waits.
*/
// Implementation choice: the strobed register port.
module sfs_core (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire sfs_pkg::sfs_req_t         req,
  output logic [31:0]                    rdata,
  input  wire sfs_pkg::sfs_shift_t       shift,
  input  wire logic                      rxd_pin,
  output logic                           rxd_sampled,
  output logic                           port_enable,
  output logic                           tx_valid,
  output logic [sfs_pkg::DATA_W-1:0]     tx_data,
  output logic                           irq
);

  // reset release through two flip-flops
  logic                           rst_s1_q;
  logic                           rst_n_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // fifo storage and pointers
  logic [sfs_pkg::DATA_W-1:0]     txm_q [sfs_pkg::FIFO_DEPTH];
  logic [sfs_pkg::DATA_W-1:0]     rxm_q [sfs_pkg::FIFO_DEPTH];
  logic [sfs_pkg::PTR_W-1:0]      tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [sfs_pkg::PTR_W-1:0]      rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [sfs_pkg::CNT_W-1:0]      tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic                           en_q, en_d;
  logic [2:0]                     tx_thr_q, tx_thr_d, rx_thr_q, rx_thr_d;
  logic [5:0]                     mask_q, mask_d;
  logic [5:0]                     sticky_q, sticky_d;
  logic                           txerr_q, txerr_d, collision_error_q, collision_error_d;
  logic [7:0]                     dly_q, dly_d;
  logic [31:0]                    scr_a_q, scr_a_d, scr_b_q, scr_b_d;
  logic [31:0]                    rdata_q, rdata_d;
  logic [7:0]                     rxd_hist_q;
  logic                           rxd_s1_q, rxd_s2_q;
  logic                           rxd_out_q;

  // decode helper, used for every register select except the read data case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  logic                           wr_data, rd_data, tx_push, tx_pop, rx_push, rx_pop;
  logic                           tx_full, tx_empty, rx_full, rx_empty;
  logic [5:0]                     src, masked, events;

  // fifo flags and handshakes; disabled port accepts nothing
  always_comb begin
    tx_full  = tx_cnt_q == sfs_pkg::FIFO_FULL_CNT;
    tx_empty = tx_cnt_q == '0;
    rx_full  = rx_cnt_q == sfs_pkg::FIFO_FULL_CNT;
    rx_empty = rx_cnt_q == '0;
    wr_data  = req.wr && hit(req.addr, sfs_pkg::OFF_DATA) && en_q;
    rd_data  = req.rd && hit(req.addr, sfs_pkg::OFF_DATA) && en_q;
    tx_push  = wr_data && !tx_full;
    tx_pop   = shift.tx_pop && en_q && !tx_empty;
    rx_push  = shift.rx_push && en_q && !rx_full;
    rx_pop   = rd_data && !rx_empty;
  end

  // fifo pointer and count next state
  always_comb begin
    tx_wp_d  = tx_wp_q + sfs_pkg::PTR_W'(tx_push);
    tx_rp_d  = tx_rp_q + sfs_pkg::PTR_W'(tx_pop);
    rx_wp_d  = rx_wp_q + sfs_pkg::PTR_W'(rx_push);
    rx_rp_d  = rx_rp_q + sfs_pkg::PTR_W'(rx_pop);
    tx_cnt_d = tx_cnt_q + sfs_pkg::CNT_W'(tx_push) - sfs_pkg::CNT_W'(tx_pop);
    rx_cnt_d = rx_cnt_q + sfs_pkg::CNT_W'(rx_push) - sfs_pkg::CNT_W'(rx_pop);
    if (!en_q) begin
      tx_wp_d  = '0;
      tx_rp_d  = '0;
      rx_wp_d  = '0;
      rx_rp_d  = '0;
      tx_cnt_d = '0;
      rx_cnt_d = '0;
    end
  end

  // fifo storage writes, indexed by write pointer
  always_ff @(posedge sys_clk) begin
    if (tx_push) txm_q[tx_wp_q] <= req.wdata[sfs_pkg::DATA_W-1:0];
    if (rx_push) rxm_q[rx_wp_q] <= shift.rx_data;
  end

  // interrupt sources: levels for thresholds, sticky for error events
  always_comb begin
    events                         = '0;
    events[sfs_pkg::IRQ_TX_OVER]   = wr_data && tx_full;
    events[sfs_pkg::IRQ_RX_UNDER]  = rd_data && rx_empty;
    events[sfs_pkg::IRQ_RX_OVER]   = shift.rx_push && en_q && rx_full;
    events[sfs_pkg::IRQ_CONTENTION] = shift.contention && en_q;
    sticky_d = sticky_q;
    if (req.wr && hit(req.addr, sfs_pkg::OFF_INT_CLEAR)) sticky_d = sticky_q & ~req.wdata[5:0];
    sticky_d = sticky_d | events;                                                    // set wins over clear
    src                            = sticky_q;
    src[sfs_pkg::IRQ_TX_EMPTY]     = en_q && ({1'b0, tx_thr_q} >= tx_cnt_q);
    src[sfs_pkg::IRQ_RX_FULL]      = en_q && (rx_cnt_q >= {1'b0, rx_thr_q});
    masked                         = src & mask_q;
  end

  // status error bits: set by engine, cleared on status read, set wins
  always_comb begin
    txerr_d = txerr_q;
    collision_error_d  = collision_error_q;
    if (req.rd && hit(req.addr, sfs_pkg::OFF_STATUS)) begin
      txerr_d = 1'b0;
      collision_error_d  = 1'b0;
    end
    if (shift.xfer_start && en_q && tx_empty) txerr_d = 1'b1;
    if (shift.collision && en_q) collision_error_d = 1'b1;
    if (!en_q) begin
      txerr_d = 1'b0;
      collision_error_d  = 1'b0;
    end
  end

  // register writes
  always_comb begin
    en_d     = en_q;
    tx_thr_d = tx_thr_q;
    rx_thr_d = rx_thr_q;
    mask_d   = mask_q;
    dly_d    = dly_q;
    scr_a_d  = scr_a_q;
    scr_b_d  = scr_b_q;
    if (req.wr) begin
      if (hit(req.addr, sfs_pkg::OFF_ENABLE))     en_d     = req.wdata[0];
      if (hit(req.addr, sfs_pkg::OFF_TX_THRESH))  tx_thr_d = req.wdata[2:0];
      if (hit(req.addr, sfs_pkg::OFF_RX_THRESH))  rx_thr_d = req.wdata[2:0];
      if (hit(req.addr, sfs_pkg::OFF_INT_MASK))   mask_d   = req.wdata[5:0];
      if (hit(req.addr, sfs_pkg::OFF_SAMPLE_DLY)) dly_d    = req.wdata[7:0];
      if (hit(req.addr, sfs_pkg::OFF_SCRATCH_A))  scr_a_d  = req.wdata;
      if (hit(req.addr, sfs_pkg::OFF_SCRATCH_B))  scr_b_d  = req.wdata;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      unique case (req.addr)
        sfs_pkg::OFF_ENABLE:     rdata_d = {31'h0, en_q};
        sfs_pkg::OFF_TX_THRESH:  rdata_d = {29'h0, tx_thr_q};
        sfs_pkg::OFF_RX_THRESH:  rdata_d = {29'h0, rx_thr_q};
        sfs_pkg::OFF_TX_LEVEL:   rdata_d = {28'h0, tx_cnt_q};
        sfs_pkg::OFF_RX_LEVEL:   rdata_d = {28'h0, rx_cnt_q};
        sfs_pkg::OFF_STATUS:     rdata_d = {25'h0, collision_error_q, txerr_q, rx_full, !rx_empty,
                                            tx_empty, !tx_full, shift.xfer_active && en_q};
        sfs_pkg::OFF_INT_MASK:   rdata_d = {26'h0, mask_q};
        sfs_pkg::OFF_INT_MASKED: rdata_d = {26'h0, masked};
        sfs_pkg::OFF_INT_RAW:    rdata_d = {26'h0, src};
        sfs_pkg::OFF_DATA:       rdata_d = rx_empty ? 32'h0 : {16'h0, rxm_q[rx_rp_q]};
        sfs_pkg::OFF_SCRATCH_A:  rdata_d = scr_a_q;
        sfs_pkg::OFF_SCRATCH_B:  rdata_d = scr_b_q;
        sfs_pkg::OFF_SAMPLE_DLY: rdata_d = {24'h0, dly_q};
        default:                 rdata_d = '0;
      endcase
    end
  end

  // register bank
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
      en_q     <= 1'b0;
      tx_thr_q <= sfs_pkg::RST_THRESH;
      rx_thr_q <= sfs_pkg::RST_THRESH;
      mask_q   <= sfs_pkg::RST_INT_MASK;
      sticky_q <= '0;
      txerr_q  <= 1'b0;
      collision_error_q   <= 1'b0;
      dly_q    <= sfs_pkg::RST_SAMPLE_DLY;
      scr_a_q  <= sfs_pkg::RST_SCRATCH;
      scr_b_q  <= sfs_pkg::RST_SCRATCH;
      rdata_q  <= '0;
    end else begin
      tx_wp_q  <= tx_wp_d;
      tx_rp_q  <= tx_rp_d;
      rx_wp_q  <= rx_wp_d;
      rx_rp_q  <= rx_rp_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      en_q     <= en_d;
      tx_thr_q <= tx_thr_d;
      rx_thr_q <= rx_thr_d;
      mask_q   <= mask_d;
      sticky_q <= sticky_d;
      txerr_q  <= txerr_d;
      collision_error_q   <= collision_error_d;
      dly_q    <= dly_d;
      scr_a_q  <= scr_a_d;
      scr_b_q  <= scr_b_d;
      rdata_q  <= rdata_d;
    end
  end

  // receive pin: two-stage sync, then a delay line tapped by the sample delay
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rxd_s1_q   <= 1'b0;
      rxd_s2_q   <= 1'b0;
      rxd_hist_q <= '0;
      rxd_out_q  <= 1'b0;
    end else begin
      rxd_s1_q   <= rxd_pin;
      rxd_s2_q   <= rxd_s1_q;
      rxd_hist_q <= {rxd_hist_q[6:0], rxd_s2_q};
      rxd_out_q  <= (dly_q == 8'h00) ? rxd_s2_q :
                    (dly_q > 8'h08) ? rxd_hist_q[7] : rxd_hist_q[dly_q[2:0] - 3'h1];
    end
  end

  assign rdata       = rdata_q;
  assign rxd_sampled = rxd_out_q;
  assign port_enable = en_q;
  assign tx_valid    = !tx_empty && en_q;
  assign tx_data     = txm_q[tx_rp_q];
  assign irq         = |masked;

  // checks
  property p_txlvl;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (en_q && tx_push && !tx_pop && en_d) |=> tx_cnt_q == $past(tx_cnt_q) + 4'h1;
  endproperty
  a_txlvl: assert property (p_txlvl) else $error("tx level not incremented");
  property p_rxlvl;
    @(posedge sys_clk) disable iff (!rst_n_q) rx_cnt_q <= sfs_pkg::FIFO_FULL_CNT;
  endproperty
  a_rxlvl: assert property (p_rxlvl) else $error("rx level past depth");
  property p_rxfull;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (en_q && rx_cnt_q >= {1'b0, rx_thr_q}) |-> src[sfs_pkg::IRQ_RX_FULL];
  endproperty
  a_rxfull: assert property (p_rxfull) else $error("rx full source missing");
  property p_txemp;
    @(posedge sys_clk) disable iff (!rst_n_q)
      src[sfs_pkg::IRQ_TX_EMPTY] |-> (en_q && tx_cnt_q <= {1'b0, tx_thr_q});
  endproperty
  a_txemp: assert property (p_txemp) else $error("tx empty source wrong");
  property p_txerr;
    @(posedge sys_clk) disable iff (!rst_n_q) (shift.xfer_start && en_q && tx_empty && en_d) |=> txerr_q;
  endproperty
  a_txerr: assert property (p_txerr) else $error("transmission error not set");
  property p_collision_error;
    @(posedge sys_clk) disable iff (!rst_n_q) (shift.collision && en_q && en_d) |=> collision_error_q;
  endproperty
  a_collision_error: assert property (p_collision_error) else $error("collision not set");
  property p_ovr;
    @(posedge sys_clk) disable iff (!rst_n_q) (wr_data && tx_full) |=> sticky_q[sfs_pkg::IRQ_TX_OVER];
  endproperty
  a_ovr: assert property (p_ovr) else $error("tx overflow not latched");
  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n_q) irq == |(src & mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq disagrees with mask");
  property p_dis;
    @(posedge sys_clk) disable iff (!rst_n_q) !en_q |=> (tx_cnt_q == 4'h0 && rx_cnt_q == 4'h0);
  endproperty
  a_dis: assert property (p_dis) else $error("fifo kept while disabled");
  property p_scr;
    @(posedge sys_clk) disable iff (!rst_n_q)
      (req.wr && hit(req.addr, sfs_pkg::OFF_SCRATCH_A)) |=> scr_a_q == $past(req.wdata);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch write lost");
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n_q) $rose(irq));
  c_full: cover property (@(posedge sys_clk) disable iff (!rst_n_q) tx_full);
  c_under: cover property (@(posedge sys_clk) disable iff (!rst_n_q) events[sfs_pkg::IRQ_RX_UNDER]);

endmodule : sfs_core

// ===== include/sfs_pkg.sv
/*
  Package for the serial port FIFO, status and interrupt block: register offsets, field positions,
  reset values, depths and the packed structs that carry grouped signals.
  Assumes a 32-bit register port with word-aligned byte offsets and one clock domain.
*/
package sfs_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_ENABLE      = 8'h08;
  localparam logic [7:0] OFF_TX_THRESH   = 8'h18;
  localparam logic [7:0] OFF_RX_THRESH   = 8'h1C;
  localparam logic [7:0] OFF_TX_LEVEL    = 8'h20;
  localparam logic [7:0] OFF_RX_LEVEL    = 8'h24;
  localparam logic [7:0] OFF_STATUS      = 8'h28;
  localparam logic [7:0] OFF_INT_MASK    = 8'h2C;
  localparam logic [7:0] OFF_INT_MASKED  = 8'h30;
  localparam logic [7:0] OFF_INT_RAW     = 8'h34;
  localparam logic [7:0] OFF_INT_CLEAR   = 8'h48;
  localparam logic [7:0] OFF_DATA        = 8'h60;
  localparam logic [7:0] OFF_SCRATCH_A   = 8'hF4;
  localparam logic [7:0] OFF_SCRATCH_B   = 8'hF8;
  localparam logic [7:0] OFF_SAMPLE_DLY  = 8'hFC;

  // fifo geometry
  localparam int         FIFO_DEPTH      = 8;
  localparam int         PTR_W           = 3;
  localparam int         CNT_W           = 4;
  localparam int         DATA_W          = 16;
  localparam logic [3:0] FIFO_FULL_CNT   = 4'h8;

  // status bit positions
  localparam int         ST_BUSY         = 0;
  localparam int         ST_TX_NOT_FULL  = 1;
  localparam int         ST_TX_EMPTY     = 2;
  localparam int         ST_RX_NOT_EMPTY = 3;
  localparam int         ST_RX_FULL      = 4;
  localparam int         ST_TX_ERR       = 5;
  localparam int         ST_COLLISION    = 6;

  // interrupt source positions
  localparam int         IRQ_TX_EMPTY    = 0;
  localparam int         IRQ_TX_OVER     = 1;
  localparam int         IRQ_RX_UNDER    = 2;
  localparam int         IRQ_RX_OVER     = 3;
  localparam int         IRQ_RX_FULL     = 4;
  localparam int         IRQ_CONTENTION  = 5;
  localparam int         IRQ_W           = 6;

  // reset values
  localparam logic [5:0]  RST_INT_MASK   = 6'h3F;
  localparam logic [2:0]  RST_THRESH     = 3'h0;
  localparam logic [7:0]  RST_SAMPLE_DLY = 8'h00;
  localparam logic [31:0] RST_SCRATCH    = 32'h0000_0000;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sfs_req_t;

  // serial engine events toward the block
  typedef struct packed {
    logic              xfer_start;
    logic              xfer_active;
    logic              tx_pop;
    logic              rx_push;
    logic [DATA_W-1:0] rx_data;
    logic              collision;
    logic              contention;
  } sfs_shift_t;

endpackage : sfs_pkg

// ===== test/sfs_engine_model.sv
/*
  Stand-in for the serial shift engine: starts transfers, takes tx words, hands over rx words
  and raises collision or contention pulses. Assumes the core's clock and calls from the bench.
*/
module sfs_engine_model (
  input  wire logic            sys_clk,
  input  wire logic            tx_valid,
  output sfs_pkg::sfs_shift_t  shift
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet engine from time zero
  initial shift = '0;

  // begin a transfer and stay busy until finish
  task automatic start();
    @(posedge sys_clk);
    shift.xfer_start  <= 1'b1;
    shift.xfer_active <= 1'b1;
    @(posedge sys_clk);
    shift.xfer_start  <= 1'b0;
  endtask : start

  // end the transfer: take a tx word only if one is offered, push one rx word
  task automatic finish(input logic [15:0] word);
    repeat (2) @(posedge sys_clk);
    shift.tx_pop      <= tx_valid;
    shift.rx_push     <= 1'b1;
    shift.rx_data     <= word;
    shift.xfer_active <= 1'b0;
    @(posedge sys_clk);
    shift.tx_pop      <= 1'b0;
    shift.rx_push     <= 1'b0;
    shift.rx_data     <= ~word;  // released data does not keep its value
  endtask : finish

  // one-cycle collision pulse when coll is high, contention pulse otherwise
  task automatic flag(input logic coll);
    @(posedge sys_clk);
    shift.collision  <= coll;
    shift.contention <= ~coll;
    @(posedge sys_clk);
    shift.collision  <= 1'b0;
    shift.contention <= 1'b0;
  endtask : flag
endmodule : sfs_engine_model

// ===== test/tb_top.sv
/*
  Self-checking bench for the serial port fifo, status and interrupt core.
  Assumes the register port of the core and the engine stand-in on one 50 MHz clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                sys_clk = 1'b0;
  logic                nrst    = 1'b0;
  sfs_pkg::sfs_req_t   req     = '0;
  logic                rxd_pin = 1'b0;
  sfs_pkg::sfs_shift_t shift;
  logic [31:0]         rdata;
  logic [15:0]         tx_data;
  logic                rxd_sampled;
  logic                port_enable;
  logic                tx_valid;
  logic                irq;
  int                  err_total    = 0;
  int                  total_checks = 0;
  int                  cycles       = 0;
  int                  n0;
  int                  n3;
  logic [7:0]          ra [11] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'hF4, 8'hF8, 8'hFC, 8'h40};
  logic [31:0]         rv [11] = '{32'h0, 32'h0, 32'h0, 32'h6, 32'h3F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  // 20 ns clock
  always #10 sys_clk = ~sys_clk;

  sfs_core u_sfs_core (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .req         (req),
    .rdata       (rdata),
    .shift       (shift),
    .rxd_pin     (rxd_pin),
    .rxd_sampled (rxd_sampled),
    .port_enable (port_enable),
    .tx_valid    (tx_valid),
    .tx_data     (tx_data),
    .irq         (irq)
  );

  sfs_engine_model u_sfs_engine_model (
    .sys_clk  (sys_clk),
    .tx_valid (tx_valid),
    .shift    (shift)
  );

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr    <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd   <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, rdata);
  endtask : rd

  // interrupt line level once updates have landed
  task automatic irq_is(input logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is

  // flip the serial input and count edges until the sampled copy follows
  task automatic meas(output int n);
    @(posedge sys_clk);
    rxd_pin <= ~rxd_pin;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rxd_sampled !== rxd_pin && n < 40);
  endtask : meas

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], rv[i]);
    end
    $display("test reset_values done");
    wr(8'hF4, 32'hA5A5_5A5A);
    wr(8'hF8, 32'h0123_4567);
    wr(8'h40, 32'hFFFF_FFFF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'hF4, 32'hA5A5_5A5A);
    rd(8'hF8, 32'h0123_4567);
    rd(8'h40, 32'h0);
    rd(8'h20, 32'h0);
    $display("test scratch done");
    wr(8'h1C, 32'h2);
    rd(8'h1C, 32'h2);
    irq_is(1'b0);
    wr(8'h08, 32'h1);
    rd(8'h34, 32'h1);
    rd(8'h30, 32'h1);
    irq_is(1'b1);
    wr(8'h2C, 32'h3E);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h1);
    irq_is(1'b0);
    wr(8'h2C, 32'h3F);
    $display("test mask done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h60, 32'h1000 + 32'(i));
    end
    rd(8'h20, 32'h8);
    rd(8'h28, 32'h0);
    wr(8'h60, 32'hFFFF);
    rd(8'h20, 32'h8);
    rd(8'h34, 32'h2);
    wr(8'h18, 32'h7);
    $display("test fill done");
    for (int i = 0; i < 8; i++) begin
      u_sfs_engine_model.start();
      if (i == 0) rd(8'h28, 32'h1);
      #1;
      chk("tx head", 32'h1000 + 32'(i), {16'h0, tx_data});
      u_sfs_engine_model.finish(16'hC000 + 16'(i));
      if (i == 1) rd(8'h34, 32'h13);
    end
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h8);
    rd(8'h28, 32'h1E);
    u_sfs_engine_model.start();
    u_sfs_engine_model.finish(16'hBEEF);
    rd(8'h34, 32'h1B);
    rd(8'h28, 32'h3E);
    rd(8'h28, 32'h1E);
    u_sfs_engine_model.flag(1'b1);
    rd(8'h28, 32'h5E);
    rd(8'h28, 32'h1E);
    $display("test transfer done");
    for (int i = 0; i < 8; i++) begin
      rd(8'h60, 32'hC000 + 32'(i));
    end
    rd(8'h60, 32'h0);
    rd(8'h24, 32'h0);
    u_sfs_engine_model.flag(1'b0);
    rd(8'h34, 32'h2F);
    rd(8'h30, 32'h2F);
    irq_is(1'b1);
    wr(8'h48, 32'h3E);
    rd(8'h34, 32'h1);
    wr(8'h2C, 32'h3E);
    irq_is(1'b0);
    $display("test receive done");
    meas(n0);
    wr(8'hFC, 32'h3);
    rd(8'hFC, 32'h3);
    meas(n3);
    chk("sample delay", 32'(n0 + 3), 32'(n3));
    $display("test sample_delay done");
    wr(8'h60, 32'h0055);
    #1;
    chk("tx_valid", 32'h1, {31'h0, tx_valid});
    chk("port_enable", 32'h1, {31'h0, port_enable});
    wr(8'h08, 32'h0);
    #1;
    chk("port_enable", 32'h0, {31'h0, port_enable});
    chk("tx_valid", 32'h0, {31'h0, tx_valid});
    wr(8'h60, 32'h0066);
    rd(8'h20, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h28, 32'h6);
    $display("test disable done");
    wrap_up();
  end
endmodule : tb_top
